// *** pfcs_pkg.sv ***
/*
  Package for the parallel flash command sequencer host: command addresses and data,
  bus cycle timing counts, operation codes and the carrier structs.
  Assumes a 25 MHz system clock.
*/
package pfcs_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Command words
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_ADDR_A = 16'h5555;
  localparam logic [15:0] CMD_ADDR_B = 16'h2aaa;
  localparam logic [7:0] KEY_A = 8'haa;
  localparam logic [7:0] KEY_B = 8'h55;
  localparam logic [7:0] CMD_SETUP = 8'h80;
  localparam logic [7:0] CMD_ERASE = 8'h10;
  localparam logic [7:0] CMD_PROG = 8'ha0;
  localparam logic [7:0] CMD_LOCK = 8'h40;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
  localparam logic [15:0] ID_LOCK_ADDR = 16'h0002;
  localparam logic [15:0] BOOT_TOP = 16'h1fff;
  localparam int LOCK_BIT = 0;
  localparam int TOGGLE_BIT = 6;
  localparam int POLL_BIT = 7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  // Least strobe low time that clears the noise filter.
  localparam int FILTER_NS = 15;
  // Strobe low and read access hold, chosen above filter and access time.
  localparam int STROBE_NS = 80;
  localparam int READ_NS = 120;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC = (READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = 1;
  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PFCS_OP_READ,
    PFCS_OP_PROGRAM,
    PFCS_OP_CHIP_ERASE,
    PFCS_OP_LOCK_BOOT,
    PFCS_OP_ID_ENTRY,
    PFCS_OP_ID_EXIT,
    PFCS_OP_ID_EXIT_SHORT
  } pfcs_op_t;

  typedef struct packed {
    pfcs_op_t op;
    logic [15:0] addr;
    logic [7:0] data;
  } pfcs_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic lock_err;
    logic timeout;
  } pfcs_rsp_t;

  typedef struct packed {
    logic [15:0] addr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [7:0] dq_out;
    logic dq_oe;
  } pfcs_pins_t;

endpackage : pfcs_pkg

// *** pfcs_host.sv ***
/*
  Host-side controller for a 64K x 8 parallel flash: issues keyed command
  sequences, reads bytes, and waits for program or erase end by polling.
  Assumes the flash is on the pins of pins_o/dq_i and that the user holds
  req stable while req_valid is high until req_ready.
*/
`timescale 1ns/100ps
// Overview of operation
// - Chip erase six-cycle keyed sequence
// - Byte program four-cycle sequence
// - Boot lockout six-cycle keyed sequence
// - ID entry three-cycle sequence
// - ID exit three-cycle or single F0
module pfcs_host
  import pfcs_pkg::*;
#(
  parameter int POLL_LIMIT = 1000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request side
  input wire logic req_valid,
  output logic req_ready,
  input wire pfcs_req_t req,
  output logic rsp_valid,
  output pfcs_rsp_t rsp,
  // Flash pins
  output pfcs_pins_t pins_o,
  input wire logic [7:0] dq_i
);

  // Polling needs at least two reads to compare the toggle bit.
  if (POLL_LIMIT < 2) begin : g_poll_limit_check
    $error("POLL_LIMIT out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RECOVER,
    ST_READ,
    ST_POLL,
    ST_DONE
  } pfcs_state_t;

  // ----------------------------------------------------------------
  // Sequence table
  // ----------------------------------------------------------------
  function automatic logic [2:0] seq_len(input pfcs_op_t op);
    case (op)
      PFCS_OP_PROGRAM: seq_len = 3'd4;
      PFCS_OP_CHIP_ERASE, PFCS_OP_LOCK_BOOT: seq_len = 3'd6;
      PFCS_OP_ID_ENTRY, PFCS_OP_ID_EXIT: seq_len = 3'd3;
      PFCS_OP_ID_EXIT_SHORT: seq_len = 3'd1;
      default: seq_len = 3'd0;
    endcase
  endfunction : seq_len

  function automatic logic [23:0] seq_word(input pfcs_req_t r, input logic [2:0] idx);
    logic [7:0] last;
    last = CMD_ID_EXIT;
    case (r.op)
      PFCS_OP_CHIP_ERASE: last = CMD_ERASE;
      PFCS_OP_LOCK_BOOT: last = CMD_LOCK;
      PFCS_OP_ID_ENTRY: last = CMD_ID_ENTRY;
      PFCS_OP_PROGRAM: last = CMD_PROG;
      default: last = CMD_ID_EXIT;
    endcase
    if (r.op == PFCS_OP_ID_EXIT_SHORT) begin
      seq_word = {r.addr, CMD_ID_EXIT};
    end else begin
      case (idx)
        3'd0: seq_word = {CMD_ADDR_A, KEY_A};
        3'd1: seq_word = {CMD_ADDR_B, KEY_B};
        3'd2: seq_word = (r.op == PFCS_OP_CHIP_ERASE || r.op == PFCS_OP_LOCK_BOOT) ?
                         {CMD_ADDR_A, CMD_SETUP} : {CMD_ADDR_A, last};
        3'd3: seq_word = (r.op == PFCS_OP_PROGRAM) ? {r.addr, r.data} : {CMD_ADDR_A, KEY_A};
        3'd4: seq_word = {CMD_ADDR_B, KEY_B};
        default: seq_word = {CMD_ADDR_A, last};
      endcase
    end
  endfunction : seq_word

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pfcs_state_t state_q, state_d;
  pfcs_req_t req_q, req_d;
  pfcs_pins_t pins_q, pins_d;
  pfcs_rsp_t rsp_q, rsp_d;
  logic rsp_valid_q, rsp_valid_d;
  logic [2:0] idx_q, idx_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [31:0] polls_q, polls_d;
  logic have_prev_q, have_prev_d;
  logic [7:0] prev_q, prev_d;
  logic [7:0] dq_meta_q, dq_sync_q;
  logic [23:0] word;

  assign word = seq_word(req_q, idx_q);
  assign req_ready = (state_q == ST_IDLE);
  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;
  assign pins_o = pins_q;

  always_comb begin
    state_d = state_q;
    req_d = req_q;
    pins_d = pins_q;
    rsp_d = rsp_q;
    rsp_valid_d = 1'b0;
    idx_d = idx_q;
    cnt_d = cnt_q;
    polls_d = polls_q;
    have_prev_d = have_prev_q;
    prev_d = prev_q;
    case (state_q)
      ST_IDLE: begin
        pins_d.ce_n = 1'b1;
        pins_d.oe_n = 1'b1;
        pins_d.we_n = 1'b1;
        pins_d.dq_oe = 1'b0;
        if (req_valid) begin
          req_d = req;
          idx_d = 3'd0;
          rsp_d = '0;
          cnt_d = CNT_W'(SETUP_CYC);
          // every keyed sequence restarts from the first key
          if (req.op == PFCS_OP_READ) begin
            pins_d.addr = req.addr;
            state_d = ST_READ;
            cnt_d = CNT_W'(READ_CYC);
          end else begin
            state_d = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        pins_d.oe_n = 1'b1;
        pins_d.addr = word[23:8];
        pins_d.dq_out = word[7:0];
        pins_d.dq_oe = 1'b1;
        pins_d.ce_n = 1'b0;
        // The first setup cycle shows address and data with the strobe still high.
        if (cnt_q == '0) begin
          // address set before the strobe falls
          pins_d.we_n = 1'b0;
          cnt_d = CNT_W'(STROBE_CYC);
          state_d = ST_STROBE;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      ST_STROBE: begin
        // strobe held well past filter width
        if (cnt_q <= CNT_W'(1)) begin
          pins_d.we_n = 1'b1;
          state_d = ST_RECOVER;
        end else begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      ST_RECOVER: begin
        // data held past the rising strobe
        pins_d.ce_n = 1'b1;
        pins_d.dq_oe = 1'b0;
        if (idx_q + 3'd1 >= seq_len(req_q.op)) begin
          if (req_q.op == PFCS_OP_PROGRAM || req_q.op == PFCS_OP_CHIP_ERASE) begin
            pins_d.addr = req_q.addr;
            have_prev_d = 1'b0;
            polls_d = '0;
            cnt_d = CNT_W'(READ_CYC);
            state_d = ST_POLL;
          end else begin
            state_d = ST_DONE;
          end
        end else begin
          idx_d = idx_q + 3'd1;
          cnt_d = CNT_W'(SETUP_CYC);
          state_d = ST_SETUP;
        end
      end
      ST_READ, ST_POLL: begin
        // read with select and enable low
        pins_d.ce_n = 1'b0;
        pins_d.oe_n = 1'b0;
        pins_d.we_n = 1'b1;
        pins_d.dq_oe = 1'b0;
        if (cnt_q != '0) begin
          cnt_d = cnt_q - CNT_W'(1);
        end else begin
          // Release the bus so each poll is a distinct read.
          pins_d.ce_n = 1'b1;
          pins_d.oe_n = 1'b1;
          rsp_d.data = dq_sync_q;
          if (state_q == ST_READ) begin
            state_d = ST_DONE;
          end else begin
            polls_d = polls_q + 32'd1;
            have_prev_d = 1'b1;
            prev_d = dq_sync_q;
            cnt_d = CNT_W'(READ_CYC);
            // stable toggle bit means operation done
            if (have_prev_q && prev_q[TOGGLE_BIT] == dq_sync_q[TOGGLE_BIT]) begin
              rsp_d.lock_err = (req_q.op == PFCS_OP_PROGRAM) &&
                               ((dq_sync_q & req_q.data) != req_q.data ||
                                dq_sync_q[POLL_BIT] != req_q.data[POLL_BIT]);
              state_d = ST_DONE;
            end else if (polls_q >= 32'(POLL_LIMIT)) begin
              rsp_d.timeout = 1'b1;
              state_d = ST_DONE;
            end
          end
        end
      end
      ST_DONE: begin
        pins_d.ce_n = 1'b1;
        pins_d.oe_n = 1'b1;
        rsp_valid_d = 1'b1;
        state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    // Pin data crosses in from outside the clock domain.
    dq_meta_q <= dq_i;
    dq_sync_q <= dq_meta_q;
    if (rst) begin
      state_q <= ST_IDLE;
      req_q <= '0;
      pins_q <= '{addr: 16'h0000, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_out: 8'h00, dq_oe: 1'b0};
      rsp_q <= '0;
      rsp_valid_q <= 1'b0;
      idx_q <= 3'd0;
      cnt_q <= '0;
      polls_q <= '0;
      have_prev_q <= 1'b0;
      prev_q <= 8'h00;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      pins_q <= pins_d;
      rsp_q <= rsp_d;
      rsp_valid_q <= rsp_valid_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
      polls_q <= polls_d;
      have_prev_q <= have_prev_d;
      prev_q <= prev_d;
    end
  end

endmodule : pfcs_host

// *** pfcs_host_assertions.sv ***
/* Checker for the flash host pins and handshake.
   Assumes one clock with a synchronous reset. */
`timescale 1ns/100ps
module pfcs_host_assertions
  import pfcs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request side
  input wire logic req_ready,
  input wire logic rsp_valid,
  // Flash pins
  input wire pfcs_pins_t pins_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_we_needs_ce: assert property (!pins_o.we_n |-> !pins_o.ce_n && pins_o.oe_n && pins_o.dq_oe)
    else $error("write strobe without select");
  a_no_contention: assert property (pins_o.dq_oe |-> pins_o.oe_n)
    else $error("host drives data while output enabled");
  a_we_width: assert property ($fell(pins_o.we_n) |-> (!pins_o.we_n) [*2] ##1 pins_o.we_n)
    else $error("write strobe width wrong");
  a_ce_leads_we: assert property ($fell(pins_o.we_n) |-> $past(!pins_o.ce_n) && $past(pins_o.dq_oe))
    else $error("select not ahead of write strobe");
  a_wr_stable: assert property (!pins_o.we_n |=> $stable(pins_o.addr) && $stable(pins_o.dq_out))
    else $error("address or data moved during write");
  a_read_shape: assert property ($fell(pins_o.oe_n) |->
    (!pins_o.oe_n && !pins_o.ce_n && pins_o.we_n && !pins_o.dq_oe) [*3] ##1 pins_o.oe_n)
    else $error("read cycle shape wrong");
  a_idle_quiet: assert property (req_ready |-> pins_o.ce_n && pins_o.we_n)
    else $error("bus active while idle");
  a_rsp_pulse: assert property (rsp_valid |-> req_ready ##1 !rsp_valid)
    else $error("response not a single pulse");
endmodule : pfcs_host_assertions
bind pfcs_host pfcs_host_assertions pfcs_host_assertions_inst (.clk(clk), .rst(rst), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .pins_o(pins_o));

// *** pfcs_flash_model.sv ***
/* Behavioural model of the 64K x 8 flash on the host pins.
   Assumes the host clock; strobes are sampled on it. */
`timescale 1ns/100ps
module pfcs_flash_model
  import pfcs_pkg::*;
#(
  parameter int BUSY_CYC = 30,
  // Identification values are arbitrary.
  parameter logic [7:0] MFR_ID = 8'h3c,
  parameter logic [7:0] DEV_ID = 8'h5a
) (
  // Clock
  input wire logic clk,
  // Flash pins
  input wire pfcs_pins_t pins,
  output logic [7:0] dq
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  logic [7:0] dl_q = 8'h00;
  logic [15:0] a_q = 16'h0;
  logic pwe_q = 1'b1, poe_q = 1'b1, idm = 1'b0, lck = 1'b0, tog = 1'b0;
  int busy = 0, s = 0;
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
  always_comb begin
    if (pins.ce_n || pins.oe_n) dq = ~dl_q;
    else if (busy > 0) dq = {~last_q[7], tog, last_q[5:0]};
    else if (idm) dq = pins.addr == 16'h0 ? MFR_ID : pins.addr == 16'h1 ? DEV_ID : {7'h0, lck};
    else dq = mem[pins.addr];
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    s <= 0;
    if (d == CMD_ID_EXIT && (s == 0 || (s == 2 && a == CMD_ADDR_A))) idm <= 1'b0;
    else if ((s == 0 || s == 3) && a == CMD_ADDR_A && d == KEY_A) s <= s + 1;
    else if ((s == 1 || s == 4) && a == CMD_ADDR_B && d == KEY_B) s <= s + 1;
    else if (s == 2 && a == CMD_ADDR_A && d == CMD_SETUP) s <= 3;
    else if (s == 2 && a == CMD_ADDR_A && d == CMD_PROG) s <= 6;
    else if (s == 2 && a == CMD_ADDR_A && d == CMD_ID_ENTRY) idm <= 1'b1;
    else if (s == 5 && a == CMD_ADDR_A && d == CMD_LOCK) lck <= 1'b1;
    else if (s == 5 && a == CMD_ADDR_A && d == CMD_ERASE) begin
      busy <= BUSY_CYC;
      last_q <= 8'hff;
      for (int i = 0; i < 65536; i++) if (!(lck && i <= BOOT_TOP)) mem[i] <= 8'hff;
    end else if (s == 6) begin
      busy <= BUSY_CYC;
      last_q <= d;
      if (!(lck && a <= BOOT_TOP)) mem[a] <= mem[a] & d;
    end
  endtask : wr
  always @(posedge clk) begin
    pwe_q <= pins.we_n;
    poe_q <= pins.oe_n;
    if (!(pins.ce_n || pins.oe_n)) dl_q <= dq;
    if (busy > 0) busy <= busy - 1;
    if (busy > 0 && pins.oe_n && !poe_q) tog <= ~tog;
    if (pwe_q && !pins.we_n && !pins.ce_n) a_q <= pins.addr;
    if (!pwe_q && pins.we_n && !pins.ce_n && pins.oe_n && busy == 0) wr(a_q, pins.dq_out);
  end
endmodule : pfcs_flash_model

// *** parallel_flash_command_sequencer_tb.sv ***
/* Self-checking bench for the flash host against the flash model.
   Assumes nothing outside these files and the design. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module parallel_flash_command_sequencer_tb;
  import pfcs_pkg::*;
  // Arbitrary identification value.
  localparam logic [7:0] MFR = 8'h3c;
  logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_ready, rsp_valid, lck = 1'b0;
  pfcs_req_t req = '0;
  pfcs_rsp_t rsp, r;
  pfcs_pins_t pins;
  logic [7:0] fdq, d;
  logic [7:0] exp_mem [0:65535];
  logic [15:0] a;
  int num_errors = 0, n_compared = 0, seed = 32'hbf4d;
  always #20 clk = ~clk;
  pfcs_host #(.POLL_LIMIT(50)) pfcs_host_inst (.clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .pins_o(pins), .dq_i(pins.dq_oe ? pins.dq_out : fdq));
  pfcs_flash_model #(.MFR_ID(MFR)) pfcs_flash_model_inst (.clk(clk), .pins(pins), .dq(fdq));
  task end_of_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic xfer(input pfcs_op_t op, input logic [15:0] ad, input logic [7:0] dt);
    int i;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{op, ad, dt};
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    for (i = 0; i < 4000 && rsp_valid !== 1'b1; i++) @(negedge clk);
    if (i == 4000) num_errors++;
    r = rsp;
  endtask : xfer
  function automatic logic [7:0] prog_val(input logic [15:0] ad, input logic [7:0] dt);
    return (lck && ad <= BOOT_TOP) ? exp_mem[ad] : exp_mem[ad] & dt;
  endfunction : prog_val
  task automatic prog(input logic [15:0] ad, input logic [7:0] dt);
    logic [7:0] v;
    v = prog_val(ad, dt);
    exp_mem[ad] = v;
    xfer(PFCS_OP_PROGRAM, ad, dt);
    `CHK(r.lock_err, v !== dt)
    `CHK(r.timeout, 1'b0)
    xfer(PFCS_OP_READ, ad, 8'h00);
    `CHK(r.data, v)
  endtask : prog
  initial begin
    #(40 * 40000);
    num_errors++;
    end_of_test();
  end
  initial begin
    for (int i = 0; i < 65536; i++) exp_mem[i] = 8'hff;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    xfer(PFCS_OP_ID_ENTRY, 16'h0, 8'h0);
    xfer(PFCS_OP_READ, 16'h0, 8'h0);
    `CHK(r.data, MFR)
    xfer(PFCS_OP_READ, ID_LOCK_ADDR, 8'h0);
    `CHK(r.data[LOCK_BIT], 1'b0)
    a = $random(seed);
    xfer(PFCS_OP_ID_EXIT_SHORT, a, CMD_ID_EXIT);
    xfer(PFCS_OP_READ, 16'h0, 8'h0);
    `CHK(r.data, 8'hff)
    for (int i = 0; i < 12; i++) begin
      a = $random(seed);
      d = $random(seed);
      prog(16'h3000 | a[1:0], d);
    end
    prog(16'h0010, 8'h12);
    xfer(PFCS_OP_LOCK_BOOT, 16'h0, 8'h0);
    lck = 1'b1;
    xfer(PFCS_OP_ID_ENTRY, 16'h0, 8'h0);
    xfer(PFCS_OP_READ, ID_LOCK_ADDR, 8'h0);
    `CHK(r.data[LOCK_BIT], 1'b1)
    xfer(PFCS_OP_ID_EXIT, 16'h0, 8'h0);
    prog(BOOT_TOP, 8'h00);
    prog(16'h2000, 8'h00);
    xfer(PFCS_OP_CHIP_ERASE, 16'h0, 8'h0);
    `CHK(r.timeout, 1'b0)
    xfer(PFCS_OP_READ, 16'h0010, 8'h0);
    `CHK(r.data, 8'h12)
    xfer(PFCS_OP_READ, 16'h2000, 8'h0);
    `CHK(r.data, 8'hff)
    end_of_test();
  end
endmodule : parallel_flash_command_sequencer_tb
